//--- rtl/shp_dev.sv
// Modem host port: input buffer, output buffer, flow control and mode dispatch.
// Assumes the radio side is synchronous logic on CLK; link pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module shp_dev import shp_pkg::*; #(
  parameter int IB_DEPTH_P = IB_DEPTH,
  parameter int OB_DEPTH_P = OB_DEPTH
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  shp_if.dev LINK,
  input wire logic [15:0] INTERFACE_BAUD_SETTING,
  input wire logic [31:0] PACKETIZATION_TIMEOUT,
  input wire logic [15:0] CTS_THRESHOLD_SETTING,
  input wire logic SOFTWARE_FLOW_ENABLE,
  input wire logic [2:0] RTS_PIN_CONFIG,
  output logic [7:0] RADIO_TX_DATA,
  output logic RADIO_TX_VALID,
  input wire logic RADIO_TX_READY,
  input wire logic RADIO_RX_ACTIVE,
  input wire logic [7:0] RADIO_RX_DATA,
  input wire logic RADIO_RX_VALID,
  input wire logic SLEEP_REQ,
  input wire logic CMD_REQ,
  output logic [4:0] MODE,
  output logic IB_OVF,
  output logic OB_OVF,
  output logic [15:0] IB_LEVEL
);
  localparam int IAW = $clog2(IB_DEPTH_P);
  localparam int OAW = $clog2(OB_DEPTH_P);
  localparam logic [IAW:0] IB_FULL = (IAW + 1)'(IB_DEPTH_P);
  localparam logic [OAW:0] OB_FULL = (OAW + 1)'(OB_DEPTH_P);
  localparam logic [IAW:0] GO_FREE = (IAW + 1)'(CTS_GO_FREE);

  logic [7:0] ib_mem [IB_DEPTH_P];
  logic [7:0] ob_mem [OB_DEPTH_P];
  logic [IAW-1:0] ib_wp_q, ib_rp_q;
  logic [IAW:0] ib_cnt_q, ib_free;
  logic [OAW-1:0] ob_wp_q, ob_rp_q;
  logic [OAW:0] ob_cnt_q;
  logic [7:0] rx_data, tx_byte_q;
  logic rx_valid, rx_ferr, tx_busy, tx_start_q;
  logic rts1_q, rts2_q, xoff_q, cts_stop_q, pend_xon_q, pend_xoff_q;
  logic [31:0] quiet_q;
  logic ib_wr, ib_rd, ob_wr, ob_rd, is_ctl, to_met, rts_block, tx_free, ctl_send, cts_hit, cts_go;
  shp_mode_e mode_q;

  shp_uart u_uart (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .baud_div(INTERFACE_BAUD_SETTING),
    .rxd(LINK.serial_input_line),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ferr(rx_ferr),
    .tx_data(tx_byte_q),
    .tx_start(tx_start_q),
    .tx_busy(tx_busy),
    .txd(LINK.serial_output_line)
  );

  // Framing errors never reach the buffer; rx_ferr only restarts the quiet timer
  assign is_ctl = SOFTWARE_FLOW_ENABLE && shp_is_flow(rx_data);
  assign ib_wr = rx_valid && !is_ctl && (ib_cnt_q != IB_FULL);
  assign ib_rd = (mode_q == MD_TX) && !RADIO_RX_ACTIVE && !RADIO_TX_VALID
                 && (ib_cnt_q != '0);
  assign ib_free = IB_FULL - ib_cnt_q;
  assign IB_LEVEL = 16'(ib_cnt_q);
  assign MODE = mode_q;

  always_ff @(posedge CLK) begin
    if (CE && ib_wr) ib_mem[ib_wp_q] <= rx_data;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ib_wp_q <= '0;
      ib_rp_q <= '0;
      ib_cnt_q <= '0;
      IB_OVF <= 1'b0;
    end else if (CE) begin
      IB_OVF <= rx_valid && !is_ctl && (ib_cnt_q == IB_FULL);
      if (ib_wr) ib_wp_q <= ib_wp_q + 1'b1;
      if (ib_rd) ib_rp_q <= ib_rp_q + 1'b1;
      ib_cnt_q <= ib_cnt_q + (IAW + 1)'(ib_wr) - (IAW + 1)'(ib_rd);
    end
  end

  // Byte leaves the buffer only when handed to the radio stage
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RADIO_TX_VALID <= 1'b0;
      RADIO_TX_DATA <= '0;
    end else if (CE) begin
      if (ib_rd) begin
        RADIO_TX_VALID <= 1'b1;
        RADIO_TX_DATA <= ib_mem[ib_rp_q];
      end else if (RADIO_TX_READY) begin
        RADIO_TX_VALID <= 1'b0;
      end
    end
  end

  // Quiet time on the serial line, saturating
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      quiet_q <= '0;
    end else if (CE) begin
      if (rx_valid || rx_ferr) quiet_q <= '0;
      else if (quiet_q != '1) quiet_q <= quiet_q + 32'h0000_0001;
    end
  end

  // Zero timeout: the first pending byte starts the flow at once
  assign to_met = (ib_cnt_q != '0)
                  && ((PACKETIZATION_TIMEOUT == '0) || (quiet_q >= PACKETIZATION_TIMEOUT));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_q <= MD_IDLE;
    end else if (CE) begin
      case (mode_q)
        MD_IDLE: begin
          if (RADIO_RX_ACTIVE) mode_q <= MD_RX;
          else if (to_met) mode_q <= MD_TX;
          else if (SLEEP_REQ) mode_q <= MD_SLEEP;
          else if (CMD_REQ) mode_q <= MD_CMD;
        end
        MD_TX: begin
          if ((ib_cnt_q == '0) && !RADIO_TX_VALID) mode_q <= MD_IDLE;
        end
        MD_RX: begin
          if (!RADIO_RX_ACTIVE) mode_q <= MD_IDLE;
        end
        MD_SLEEP: begin
          if (!SLEEP_REQ) mode_q <= MD_IDLE;
        end
        MD_CMD: begin
          if (!CMD_REQ) mode_q <= MD_IDLE;
        end
        default: mode_q <= MD_IDLE;
      endcase
    end
  end

  // Go also needs room above the stop point, or a threshold of 34 or more would flip CTS each cycle
  assign cts_hit = 16'(ib_free) <= CTS_THRESHOLD_SETTING;
  assign cts_go = (ib_free >= GO_FREE) && (16'(ib_free) > CTS_THRESHOLD_SETTING);

  // Hysteresis only for thresholds below 33; from 33 up CTS goes again one byte above the stop point
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cts_stop_q <= 1'b0;
    end else if (CE) begin
      if (!cts_stop_q && cts_hit) cts_stop_q <= 1'b1;
      else if (cts_stop_q && cts_go) cts_stop_q <= 1'b0;
    end
  end
  assign LINK.cts_n = cts_stop_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rts1_q <= 1'b1;
      rts2_q <= 1'b1;
    end else if (CE) begin
      rts1_q <= LINK.rts_n;
      rts2_q <= rts1_q;
    end
  end

  // XOFF from the host pauses output; XON resumes it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      xoff_q <= 1'b0;
    end else if (CE) begin
      if (!SOFTWARE_FLOW_ENABLE) xoff_q <= 1'b0;
      else if (rx_valid && (rx_data == XOFF_BYTE)) xoff_q <= 1'b1;
      else if (rx_valid && (rx_data == XON_BYTE)) xoff_q <= 1'b0;
    end
  end

  assign ob_wr = RADIO_RX_VALID && (ob_cnt_q != OB_FULL);
  assign rts_block = (RTS_PIN_CONFIG == RTS_CFG_FLOW) && rts2_q;
  assign tx_free = !tx_busy && !tx_start_q;
  assign ctl_send = pend_xoff_q || pend_xon_q;
  assign ob_rd = tx_free && !ctl_send && (ob_cnt_q != '0) && !rts_block && !xoff_q;

  always_ff @(posedge CLK) begin
    if (CE && ob_wr) ob_mem[ob_wp_q] <= RADIO_RX_DATA;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ob_wp_q <= '0;
      ob_rp_q <= '0;
      ob_cnt_q <= '0;
      OB_OVF <= 1'b0;
    end else if (CE) begin
      OB_OVF <= RADIO_RX_VALID && (ob_cnt_q == OB_FULL);
      if (ob_wr) ob_wp_q <= ob_wp_q + 1'b1;
      if (ob_rd) ob_rp_q <= ob_rp_q + 1'b1;
      ob_cnt_q <= ob_cnt_q + (OAW + 1)'(ob_wr) - (OAW + 1)'(ob_rd);
    end
  end

  // Flow bytes jump the queue, or the host would overrun before seeing them
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_start_q <= 1'b0;
      tx_byte_q <= '0;
      pend_xoff_q <= 1'b0;
      pend_xon_q <= 1'b0;
    end else if (CE) begin
      tx_start_q <= 1'b0;
      if (tx_free && pend_xoff_q) begin
        tx_start_q <= 1'b1;
        tx_byte_q <= XOFF_BYTE;
        pend_xoff_q <= 1'b0;
      end else if (tx_free && pend_xon_q) begin
        tx_start_q <= 1'b1;
        tx_byte_q <= XON_BYTE;
        pend_xon_q <= 1'b0;
      end else if (ob_rd) begin
        tx_start_q <= 1'b1;
        tx_byte_q <= ob_mem[ob_rp_q];
      end
      if (SOFTWARE_FLOW_ENABLE && !cts_stop_q && cts_hit) begin
        pend_xoff_q <= 1'b1;
        pend_xon_q <= 1'b0;
      end else if (SOFTWARE_FLOW_ENABLE && cts_stop_q && cts_go) begin
        pend_xon_q <= 1'b1;
        pend_xoff_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/shp_pkg.sv
// Shared constants, types and helpers for the serial host port.
// Assumes a single 200 MHz clock on both ends of the link.
package shp_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int DEF_BAUD = 9600;
  localparam logic [15:0] BAUD_DIV_DEF = 16'(CLK_HZ / DEF_BAUD);
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = DATA_BITS + 2;
  localparam int IB_DEPTH = 1024;
  localparam int OB_DEPTH = 1024;
  localparam logic [15:0] CTS_STOP_FREE_DEF = 16'h0041;
  localparam int CTS_GO_FREE = 34;
  localparam logic [7:0] XON_BYTE = 8'h11;
  localparam logic [7:0] XOFF_BYTE = 8'h13;
  localparam logic [2:0] RTS_CFG_FLOW = 3'h2;
  // Host register map, word index on the plain port
  localparam logic [2:0] HR_TXDATA = 3'h0;
  localparam logic [2:0] HR_RXDATA = 3'h1;
  localparam logic [2:0] HR_STATUS = 3'h2;
  localparam logic [2:0] HR_CTRL = 3'h3;
  localparam logic [2:0] HR_BAUD = 3'h4;
  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_CTS_STOP = 2;
  localparam int ST_XOFF = 3;
  localparam int CT_RTS_HOLD = 0;
  localparam int CT_SW_FLOW = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  typedef enum logic [4:0] {
    MD_IDLE = 5'h01,
    MD_TX = 5'h02,
    MD_RX = 5'h04,
    MD_SLEEP = 5'h08,
    MD_CMD = 5'h10
  } shp_mode_e;
  function automatic logic shp_is_flow(input logic [7:0] b);
    return (b == XON_BYTE) || (b == XOFF_BYTE);
  endfunction
endpackage

//--- rtl/shp_if.sv
// Serial link between the modem's host port and the host UART.
// Both ends run on one clock; the lines are still treated as asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
interface shp_if;
  logic serial_input_line;
  logic serial_output_line;
  logic cts_n;
  logic rts_n;
  modport dev (input serial_input_line, input rts_n, output serial_output_line, output cts_n);
  modport host (output serial_input_line, output rts_n, input serial_output_line, input cts_n);
endinterface
`default_nettype wire

//--- rtl/shp_uart.sv
// 8-N-1 receiver and transmitter shared by both ends.
// Assumes baud_div (clocks per bit) is at least 4 and held steady during a frame.
`timescale 1ns/1ps
`default_nettype none
module shp_uart import shp_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [15:0] baud_div,
  input wire logic rxd,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_ferr,
  input wire logic [7:0] tx_data,
  input wire logic tx_start,
  output logic tx_busy,
  output logic txd
);
  logic rx1_q, rx2_q, rx_act_q;
  logic [15:0] rx_cnt_q, tx_cnt_q;
  logic [3:0] rx_idx_q, tx_idx_q;
  logic [7:0] rx_sh_q;
  logic [FRAME_BITS-1:0] tx_sh_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx1_q <= 1'b1;
      rx2_q <= 1'b1;
    end else if (ce) begin
      rx1_q <= rxd;
      rx2_q <= rx1_q;
    end
  end

  // Centre sampling: half a bit after the falling edge, then whole bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_idx_q <= '0;
      rx_sh_q <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_ferr <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      rx_ferr <= 1'b0;
      if (!rx_act_q) begin
        if (!rx2_q) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= baud_div >> 1;
          rx_idx_q <= '0;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= baud_div - 16'h0001;
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == '0) begin
          if (rx2_q) rx_act_q <= 1'b0;  // Glitch, not a start bit
        end else if (rx_idx_q < 4'(FRAME_BITS - 1)) begin
          rx_sh_q <= {rx2_q, rx_sh_q[7:1]};
        end else begin
          rx_act_q <= 1'b0;
          if (rx2_q) begin
            rx_data <= rx_sh_q;
            rx_valid <= 1'b1;
          end else begin
            rx_ferr <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_busy <= 1'b0;
      tx_cnt_q <= '0;
      tx_idx_q <= '0;
      tx_sh_q <= '1;
      txd <= 1'b1;
    end else if (ce) begin
      if (!tx_busy) begin
        txd <= 1'b1;
        if (tx_start) begin
          tx_busy <= 1'b1;
          tx_sh_q <= {1'b1, tx_data, 1'b0};
          tx_cnt_q <= '0;
          tx_idx_q <= '0;
        end
      end else if (tx_cnt_q != '0) begin
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end else if (tx_idx_q == 4'(FRAME_BITS)) begin
        tx_busy <= 1'b0;
        txd <= 1'b1;
      end else begin
        txd <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[FRAME_BITS-1:1]};
        tx_idx_q <= tx_idx_q + 4'h1;
        tx_cnt_q <= baud_div - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/shp_host.sv
// Host UART end: register port for software, obeys CTS and XON/XOFF.
// Assumes software polls status; one byte of holding in each direction.
`timescale 1ns/1ps
`default_nettype none
module shp_host import shp_pkg::*; (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  shp_if.host LINK,
  input wire logic [2:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA
);
  logic [15:0] baud_q;
  logic [1:0] ctrl_q;
  logic [7:0] tx_hold_q, rx_hold_q, rx_data;
  logic tx_pend_q, tx_start_q, rx_full_q, xoff_q, cts1_q, cts2_q;
  logic rx_valid, tx_busy, is_ctl, go;

  shp_uart u_uart (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .baud_div(baud_q),
    .rxd(LINK.serial_output_line),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ferr(),
    .tx_data(tx_hold_q),
    .tx_start(tx_start_q),
    .tx_busy(tx_busy),
    .txd(LINK.serial_input_line)
  );

  assign is_ctl = ctrl_q[CT_SW_FLOW] && shp_is_flow(rx_data);
  assign go = tx_pend_q && !tx_busy && !tx_start_q && !cts2_q && !xoff_q;
  assign LINK.rts_n = ctrl_q[CT_RTS_HOLD];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cts1_q <= 1'b1;
      cts2_q <= 1'b1;
    end else if (CE) begin
      cts1_q <= LINK.cts_n;
      cts2_q <= cts1_q;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      baud_q <= BAUD_DIV_DEF;
      ctrl_q <= CTRL_RST;
    end else if (CE && WR) begin
      if (ADDR == HR_BAUD) baud_q <= WDATA;
      if (ADDR == HR_CTRL) ctrl_q <= WDATA[1:0];
    end
  end

  // A write to the data register while a byte waits is dropped
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_pend_q <= 1'b0;
      tx_start_q <= 1'b0;
      tx_hold_q <= '0;
    end else if (CE) begin
      tx_start_q <= go;
      if (go) tx_pend_q <= 1'b0;
      if (WR && (ADDR == HR_TXDATA) && !tx_pend_q) begin
        tx_pend_q <= 1'b1;
        tx_hold_q <= WDATA[7:0];
      end
    end
  end

  // New byte wins over a read in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_full_q <= 1'b0;
      rx_hold_q <= '0;
      xoff_q <= 1'b0;
    end else if (CE) begin
      if (RD && (ADDR == HR_RXDATA)) rx_full_q <= 1'b0;
      if (!ctrl_q[CT_SW_FLOW]) xoff_q <= 1'b0;
      if (rx_valid && is_ctl) begin
        xoff_q <= (rx_data == XOFF_BYTE);
      end else if (rx_valid) begin
        rx_full_q <= 1'b1;
        rx_hold_q <= rx_data;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= '0;
      if (RD) begin
        case (ADDR)
          HR_RXDATA: RDATA <= {8'h00, rx_hold_q};
          HR_STATUS: begin
            RDATA[ST_TX_BUSY] <= tx_pend_q || tx_busy || tx_start_q;
            RDATA[ST_RX_FULL] <= rx_full_q;
            RDATA[ST_CTS_STOP] <= cts2_q;
            RDATA[ST_XOFF] <= xoff_q;
          end
          HR_CTRL: RDATA <= {14'h0000, ctrl_q};
          HR_BAUD: RDATA <= baud_q;
          default: RDATA <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/shp_sva.sv
// Checker for the serial link between the modem port and the host UART.
// Assumes 16 clocks per bit on both ends and RTS flow configured on the modem.
`timescale 1ns/1ps
`default_nettype none
module shp_sva (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic serial_input_line,
  input wire logic serial_output_line,
  input wire logic cts_n,
  input wire logic rts_n
);
  localparam int BIT_MAX = 150;
  logic [3:0] cts_hi_q;
  logic [3:0] rts_hi_q;
  // Saturating ages of each stop request; syncs make starts lag by a few cycles
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) cts_hi_q <= 4'h0;
    else if (!cts_n) cts_hi_q <= 4'h0;
    else if (cts_hi_q != 4'hF) cts_hi_q <= cts_hi_q + 4'h1;
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) rts_hi_q <= 4'h0;
    else if (!rts_n) rts_hi_q <= 4'h0;
    else if (rts_hi_q != 4'hF) rts_hi_q <= rts_hi_q + 4'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_rst_lines;
    $rose(ARST_N) |-> serial_input_line && serial_output_line;
  endproperty
  a_rst_lines: assert property (p_rst_lines) else $error("line not idle after reset");
  property p_rst_flow;
    $rose(ARST_N) |-> !cts_n && !rts_n;
  endproperty
  a_rst_flow: assert property (p_rst_flow) else $error("flow lines not go after reset");
  property p_dev_low_bit;
    $fell(serial_output_line) |-> !serial_output_line [*8];
  endproperty
  a_dev_low_bit: assert property (p_dev_low_bit) else $error("modem low bit too short");
  property p_host_low_bit;
    $fell(serial_input_line) |-> !serial_input_line [*8];
  endproperty
  a_host_low_bit: assert property (p_host_low_bit) else $error("host low bit too short");
  property p_dev_stop;
    $fell(serial_output_line) |-> ##[1:BIT_MAX] serial_output_line;
  endproperty
  a_dev_stop: assert property (p_dev_stop) else $error("modem line stuck low");
  property p_host_stop;
    $fell(serial_input_line) |-> ##[1:BIT_MAX] serial_input_line;
  endproperty
  a_host_stop: assert property (p_host_stop) else $error("host line stuck low");
  property p_host_cts;
    $fell(serial_input_line) |-> cts_hi_q < 4'h7;
  endproperty
  a_host_cts: assert property (p_host_cts) else $error("host sent during stop");
  property p_dev_rts;
    $fell(serial_output_line) |-> rts_hi_q < 4'h7;
  endproperty
  a_dev_rts: assert property (p_dev_rts) else $error("modem sent while held");
  c_cts_stop: cover property ($rose(cts_n));
  c_dev_frame: cover property ($fell(serial_output_line));
  c_rts_block: cover property (rts_hi_q == 4'hF);
endmodule
`default_nettype wire

//--- tb/serial_host_port_flow_ctrl_test.sv
// Bench: modem port and host UART joined over the link, radio side driven here.
// Assumes 16 clocks per bit; small buffers keep flow-control runs short.
`timescale 1ns/1ps
`default_nettype none
module serial_host_port_flow_ctrl_test;
  import shp_pkg::*;
  localparam int IBD = 128;
  localparam int OBD = 16;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] RDATA;
  logic [15:0] baud = 16'h0010;
  logic [31:0] tmo = 32'h000000C8;
  logic [15:0] thr = CTS_STOP_FREE_DEF;
  logic swf = 1'b0;
  logic [2:0] rts_cfg = RTS_CFG_FLOW;
  logic rdy = 1'b0;
  logic rx_act = 1'b0;
  logic [7:0] rx_d = 8'h00;
  logic rx_v = 1'b0;
  logic slp = 1'b0;
  logic cmd = 1'b0;
  logic [7:0] RADIO_TX_DATA;
  logic RADIO_TX_VALID;
  logic [4:0] MODE;
  logic IB_OVF;
  logic OB_OVF;
  logic [15:0] IB_LEVEL;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int ob_ovf_n = 0;
  int ib_ovf_n = 0;
  logic [7:0] hq[$];
  logic [7:0] dq[$];
  logic [7:0] hb;
  logic [7:0] db;
  shp_if shp_if_i ();
  wire logic [1:0] ln = {shp_if_i.serial_output_line, shp_if_i.serial_input_line};
  shp_dev #(.IB_DEPTH_P(IBD), .OB_DEPTH_P(OBD)) shp_dev_i (.CLK(CLK), .ARST_N(ARST_N),
    .CE(1'b1), .LINK(shp_if_i), .INTERFACE_BAUD_SETTING(baud), .PACKETIZATION_TIMEOUT(tmo),
    .CTS_THRESHOLD_SETTING(thr), .SOFTWARE_FLOW_ENABLE(swf), .RTS_PIN_CONFIG(rts_cfg),
    .RADIO_TX_DATA(RADIO_TX_DATA), .RADIO_TX_VALID(RADIO_TX_VALID), .RADIO_TX_READY(rdy),
    .RADIO_RX_ACTIVE(rx_act), .RADIO_RX_DATA(rx_d), .RADIO_RX_VALID(rx_v), .SLEEP_REQ(slp),
    .CMD_REQ(cmd), .MODE(MODE), .IB_OVF(IB_OVF), .OB_OVF(OB_OVF), .IB_LEVEL(IB_LEVEL));
  shp_host shp_host_i (.CLK(CLK), .ARST_N(ARST_N), .CE(1'b1), .LINK(shp_if_i), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  shp_sva shp_sva_i (.CLK(CLK), .ARST_N(ARST_N),
    .serial_input_line(shp_if_i.serial_input_line),
    .serial_output_line(shp_if_i.serial_output_line),
    .cts_n(shp_if_i.cts_n), .rts_n(shp_if_i.rts_n));
  always #2.5 CLK = ~CLK;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Budget covers every scenario with margin; a hang ends as a mismatch
  always @(posedge CLK) begin
    cyc++;
    if (OB_OVF === 1'b1) ob_ovf_n++;
    if (IB_OVF === 1'b1) ib_ovf_n++;
    if (cyc == 60000) begin
      err_total++;
      end_of_test();
    end
  end
  // Mid-bit decoder of one line; samples at edges, lines only move at bit borders
  task automatic grab(input int k, output logic [7:0] b);
    @(negedge ln[k]);
    repeat (8) @(posedge CLK);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge CLK);
      b[i] = ln[k];
    end
    repeat (16) @(posedge CLK);
    chk("stop bit", 16'(ln[k]), 16'h0001);
  endtask
  always begin
    grab(0, hb);
    hq.push_back(hb);
  end
  always begin
    grab(1, db);
    dq.push_back(db);
  end
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    d = RDATA;
  endtask
  // A byte written while one is pending would be dropped, so wait for room
  task automatic send(input logic [7:0] b);
    logic [15:0] s;
    s = 16'h0001;
    for (int n = 0; n < 4000 && s[ST_TX_BUSY] !== 1'b0; n++) rd(HR_STATUS, s);
    wr(HR_TXDATA, {8'h00, b});
  endtask
  task automatic t_modes();
    shp_mode_e m[3] = '{MD_SLEEP, MD_CMD, MD_RX};
    for (int k = 0; k < 3; k++) begin
      {slp, cmd, rx_act} <= 3'h4 >> k;
      repeat (4) @(posedge CLK);
      chk("mode entered", 16'(MODE), 16'(m[k]));
      {slp, cmd, rx_act} <= 3'h0;
      repeat (4) @(posedge CLK);
      chk("mode idle", 16'(MODE), 16'(MD_IDLE));
    end
  endtask
  task automatic t_tx();
    int n;
    send(8'hA5);
    for (n = 0; n < 400 && IB_LEVEL !== 16'h0001; n++) @(posedge CLK);
    repeat (100) @(posedge CLK);
    chk("quiet wait", 16'(MODE), 16'(MD_IDLE));
    chk("wire byte", 16'(hq[$]), 16'h00A5);
    for (n = 0; n < 300 && RADIO_TX_VALID !== 1'b1; n++) @(posedge CLK);
    chk("tx mode", 16'(MODE), 16'(MD_TX));
    chk("radio byte", 16'(RADIO_TX_DATA), 16'h00A5);
    rdy <= 1'b1;
    @(posedge CLK);
    rdy <= 1'b0;
    repeat (8) @(posedge CLK);
    chk("back to idle", 16'(MODE), 16'(MD_IDLE));
    chk("buffer empty", IB_LEVEL, 16'h0000);
  endtask
  task automatic t_hold();
    int n;
    rx_act <= 1'b1;
    for (int i = 0; i < IBD - 65; i++) send(8'(i + 32));
    for (n = 0; n < 400 && IB_LEVEL !== 16'(IBD) - thr; n++) @(posedge CLK);
    repeat (4) @(posedge CLK);
    chk("cts stop", 16'(shp_if_i.cts_n), 16'h0001);
    send(8'h7E);
    repeat (400) @(posedge CLK);
    chk("held level", IB_LEVEL, 16'(IBD) - thr);
    chk("cts held", 16'(shp_if_i.cts_n), 16'h0001);
    chk("no pop", 16'(RADIO_TX_VALID), 16'h0000);
    rx_act <= 1'b0;
    rdy <= 1'b1;
    n = 0;
    for (int c = 0; c < 3000 && n < IBD - 64; c++) begin
      @(posedge CLK);
      if (RADIO_TX_VALID === 1'b1) begin
        chk("fifo order", 16'(RADIO_TX_DATA), n < IBD - 65 ? 16'(n + 32) : 16'h007E);
        n++;
      end
    end
    rdy <= 1'b0;
    chk("drained", 16'(n), 16'(IBD - 64));
    chk("cts go", 16'(shp_if_i.cts_n), 16'h0000);
  endtask
  task automatic t_out();
    logic [15:0] s;
    int n;
    wr(HR_CTRL, 16'h0001);
    rx_act <= 1'b1;
    for (int i = 0; i <= OBD; i++) begin
      @(posedge CLK);
      rx_d <= 8'(8'hC0 + i);
      rx_v <= 1'b1;
    end
    @(posedge CLK);
    rx_v <= 1'b0;
    rx_act <= 1'b0;
    repeat (400) @(posedge CLK);
    chk("ob overflow", 16'(ob_ovf_n), 16'h0001);
    chk("held output", 16'(dq.size()), 16'h0000);
    wr(HR_CTRL, 16'h0000);
    n = 0;
    for (int c = 0; c < 3000 && n < OBD; c++) begin
      rd(HR_STATUS, s);
      if (s[ST_RX_FULL] === 1'b1) begin
        rd(HR_RXDATA, s);
        chk("host byte", s, 16'(8'hC0 + n));
        n++;
      end
    end
    chk("host count", 16'(n), 16'(OBD));
    chk("wire out", 16'(dq[0]), 16'h00C0);
  endtask
  task automatic t_swf();
    rx_act <= 1'b1;
    swf <= 1'b1;
    send(XOFF_BYTE);
    repeat (300) @(posedge CLK);
    chk("flow byte eaten", IB_LEVEL, 16'h0000);
    swf <= 1'b0;
    send(XON_BYTE);
    repeat (300) @(posedge CLK);
    chk("flow byte kept", IB_LEVEL, 16'h0001);
    chk("ib overflow", 16'(ib_ovf_n), 16'h0000);
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    wr(HR_BAUD, 16'h0010);
    t_modes();
    t_tx();
    t_hold();
    t_out();
    t_swf();
    end_of_test();
  end
endmodule
`default_nettype wire
